//--- core/spfc_core.sv
// self-programming flash control: arming, store/load handling, locks
// assumes core strobes are one-cycle and synchronous to mclk
`timescale 1ns/100ps
`include "spfc_defines.svh"

module spfc_core #(
  parameter logic [`SPFC_PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_PAGE = `SPFC_NO_READ_WHILE_WRITE_SECTION_PAGE,
  parameter logic [`SPFC_PAGE_W-1:0] BOOT_PAGE = `SPFC_NO_READ_WHILE_WRITE_SECTION_PAGE
) (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    csr_wr,
  input  wire logic [7:0]              csr_wdata,
  output      logic [7:0]              csr_rdata,
  input  wire spfc_pkg::spfc_core_req_t core_req,
  output      logic [7:0]              lpm_data,
  output      logic                    lpm_valid,
  input  wire logic [7:0]              fuse_byte,
  input  wire logic [7:0]              sig_byte,
  input  wire logic                    global_irq_en,
  input  wire logic                    pc_in_boot,
  input  wire logic                    vectors_in_boot,
  input  wire logic                    chip_erase,
  output      logic                    flash_start,
  output      logic [`SPFC_PAGE_W-1:0] flash_page,
  output      logic                    flash_erase,
  input  wire logic                    flash_done,
  input  wire logic [`SPFC_WORD_W-1:0] buf_rd_addr,
  output      logic [15:0]             buf_rd_data,
  output      logic [7:0]              lock_byte,
  output      logic                    core_halt,
  output      logic                    section_read_block,
  output      logic                    store_ready_irq,
  output      spfc_pkg::spfc_prot_t    prot
);
  import spfc_pkg::*;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic op_valid(input logic [5:0] b);
    logic ok;
    ok = (b[4:0] == `SPFC_OP_FILL) || (b[4:0] == `SPFC_OP_ERASE) ||
         (b[4:0] == `SPFC_OP_WRITE) || (b[4:0] == `SPFC_OP_LOCK) ||
         (b[4:0] == `SPFC_OP_REENABLE);
    return ok && (!b[5] || (b[4:0] == `SPFC_OP_FILL));
  endfunction

  function automatic spfc_ctl_t disarm(input spfc_ctl_t c);
    spfc_ctl_t d;
    d              = c;
    d.signature_read        = 1'b0;
    d.reenable     = 1'b0;
    d.lock_set     = 1'b0;
    d.page_write   = 1'b0;
    d.page_erase   = 1'b0;
    d.store_enable = 1'b0;
    return d;
  endfunction

  // pair {bit2, bit1}: bit1 low blocks writes, bit2 low blocks reads
  function automatic logic [1:0] pair_restrict(input logic [1:0] p);
    return {~p[1], ~p[0]};
  endfunction

  // ****************************************************
  // state and decode
  // ****************************************************
  spfc_state_t                s;
  spfc_state_t                next_s;
  logic [15:0]                page_buf [0:(1<<`SPFC_WORD_W)-1];
  logic [15:0]                buf_q;
  logic                       buf_we;
  logic [4:0]                 op;
  logic [`SPFC_PAGE_W-1:0]    z_page;
  logic [`SPFC_WORD_W-1:0]    z_word;
  logic [1:0]                 app_pair;
  logic [1:0]                 boot_pair;
  logic                       wr_blocked;
  spfc_ctl_t                  wv;

  assign op = {s.ctl.reenable, s.ctl.lock_set, s.ctl.page_write,
               s.ctl.page_erase, s.ctl.store_enable};
  assign z_page = core_req.z[`SPFC_Z_W-1:`SPFC_WORD_W+1];
  assign z_word = core_req.z[`SPFC_WORD_W:1];
  assign wv     = spfc_ctl_t'(csr_wdata);

  assign app_pair  = pair_restrict(s.lock[3:2]);
  assign boot_pair = pair_restrict(s.lock[5:4]);
  assign wr_blocked = (z_page >= BOOT_PAGE) ? boot_pair[0] : app_pair[0];

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_s             = s;
    next_s.flash_start = 1'b0;
    next_s.lpm_valid   = 1'b0;
    buf_we             = 1'b0;
    case (s.fsm)
      ST_ARMED: begin
        if (core_req.store_program_instruction && !s.ctl.signature_read) begin
          next_s.ctl = disarm(s.ctl);
          next_s.fsm = ST_IDLE;
          case (op)
            `SPFC_OP_FILL: begin
              buf_we             = 1'b1;
              next_s.loading     = 1'b1;
              next_s.ctl.busy    = 1'b0;
            end
            `SPFC_OP_ERASE, `SPFC_OP_WRITE: begin
              if (!wr_blocked) begin
                next_s.ctl         = s.ctl;
                next_s.fsm         = ST_BUSY;
                next_s.flash_start = 1'b1;
                next_s.page        = z_page;
                next_s.erase       = (op == `SPFC_OP_ERASE);
                if (z_page < NO_READ_WHILE_WRITE_SECTION_PAGE) begin
                  next_s.ctl.busy = 1'b1;
                end else begin
                  next_s.halt = 1'b1;
                end
              end
            end
            `SPFC_OP_LOCK: begin
              if (s.lock[1:0] != 2'h0) begin
                next_s.lock = s.lock &
                              (core_req.r0 | ~`SPFC_BOOT_MASK);
              end
            end
            `SPFC_OP_REENABLE: begin
              next_s.ctl.busy = 1'b0;
            end
            default: begin
              next_s.ctl = disarm(s.ctl);
            end
          endcase
        end else if (s.cnt == `SPFC_SPM_LAST) begin
          next_s.ctl = disarm(s.ctl);
          next_s.fsm = ST_IDLE;
        end else begin
          next_s.cnt = s.cnt + 3'h1;
        end
        if (core_req.load_program_instruction && (s.cnt < `SPFC_LPM_WINDOW)) begin
          if (s.ctl.signature_read) begin
            next_s.lpm_data  = sig_byte;
            next_s.lpm_valid = 1'b1;
          end else if (op == `SPFC_OP_LOCK) begin
            next_s.lpm_data  = core_req.z[0] ? s.lock : fuse_byte;
            next_s.lpm_valid = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        if (flash_done) begin
          next_s.ctl  = disarm(s.ctl);
          next_s.fsm  = ST_IDLE;
          next_s.halt = 1'b0;
          if (!s.erase) begin
            next_s.loading = 1'b0;
          end
        end
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase
    // control register write
    if (csr_wr) begin
      next_s.ctl.store_ready_irq_enable = wv.store_ready_irq_enable;
      if (s.fsm != ST_BUSY) begin
        if (wv.reenable && s.loading) begin
          next_s.loading = 1'b0;
        end
        if (op_valid(csr_wdata[5:0])) begin
          next_s.ctl.signature_read        = wv.signature_read;
          next_s.ctl.reenable     = wv.reenable;
          next_s.ctl.lock_set     = wv.lock_set;
          next_s.ctl.page_write   = wv.page_write;
          next_s.ctl.page_erase   = wv.page_erase;
          next_s.ctl.store_enable = wv.store_enable;
          next_s.fsm              = ST_ARMED;
          next_s.cnt              = 3'h0;
        end
      end
    end
    if (chip_erase) begin
      next_s.lock = `SPFC_LOCK_ERASED;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.fsm      <= ST_IDLE;
      s.ctl      <= spfc_ctl_t'(`SPFC_CSR_RESET);
      s.lock     <= `SPFC_LOCK_ERASED;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // temporary page buffer
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (buf_we) begin
      page_buf[z_word] <= {core_req.r1, core_req.r0};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= `SPFC_BUF_BLANK;
    end else begin
      buf_q <= s.loading ? page_buf[buf_rd_addr] : `SPFC_BUF_BLANK;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign csr_rdata          = s.ctl;
  assign lpm_data           = s.lpm_data;
  assign lpm_valid          = s.lpm_valid;
  assign flash_start        = s.flash_start;
  assign flash_page         = s.page;
  assign flash_erase        = s.erase;
  assign buf_rd_data        = buf_q;
  assign lock_byte          = s.lock;
  assign core_halt          = s.halt;
  assign section_read_block = s.ctl.busy;
  assign store_ready_irq    = s.ctl.store_ready_irq_enable & global_irq_en &
                              ~s.ctl.store_enable;

  always_comb begin
    prot.ext_prog_block      = ~s.lock[0];
    prot.ext_verify_block    = ~s.lock[0] & ~s.lock[1];
    prot.fuse_locked         = ~s.lock[0];
    prot.boot_locks_frozen   = ~s.lock[0] & ~s.lock[1];
    prot.app_write_block     = app_pair[0];
    prot.boot_write_block    = boot_pair[0];
    prot.boot_read_app_block = app_pair[1] & pc_in_boot;
    prot.app_read_boot_block = boot_pair[1] & ~pc_in_boot;
    prot.irq_mask            = vectors_in_boot ?
                               (app_pair[1] & ~pc_in_boot) :
                               (boot_pair[1] & pc_in_boot);
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_arm_window_bound: assert property (
    s.fsm == ST_ARMED |-> s.cnt <= `SPFC_SPM_LAST)
    else $error("arming window overran");
  a_arm_expiry_clears: assert property (
    (s.fsm == ST_ARMED && s.cnt == `SPFC_SPM_LAST && !core_req.store_program_instruction &&
     !csr_wr) |=> (!s.ctl.store_enable && s.fsm == ST_IDLE))
    else $error("armed bits survived expiry");
  a_busy_keeps_enable: assert property (
    s.fsm == ST_BUSY |-> s.ctl.store_enable)
    else $error("store enable dropped while busy");
  a_halt_only_busy: assert property (
    s.halt |-> s.fsm == ST_BUSY)
    else $error("core halted outside an operation");
  a_rww_start_busy: assert property (
    (s.flash_start && s.page < NO_READ_WHILE_WRITE_SECTION_PAGE) |-> section_read_block)
    else $error("section not blocked during program");
  a_lock_only_clears: assert property (
    !chip_erase |=> ((s.lock & ~$past(s.lock)) == 8'h00))
    else $error("lock bit returned to one");
  a_sig_store_none: assert property (
    (s.fsm == ST_ARMED && s.ctl.signature_read && core_req.store_program_instruction && !csr_wr)
    |=> (!s.flash_start && s.fsm != ST_BUSY))
    else $error("store acted during signature read");
  a_bad_write_ignored: assert property (
    (csr_wr && !op_valid(csr_wdata[5:0]) && s.fsm == ST_IDLE)
    |=> s.fsm == ST_IDLE)
    else $error("invalid control write armed");
  a_lpm_lock_read: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_LOCK && !s.ctl.signature_read &&
     core_req.load_program_instruction && core_req.z[0] && s.cnt < `SPFC_LPM_WINDOW)
    |=> (lpm_valid && lpm_data == $past(s.lock)))
    else $error("lock byte not returned");
  a_fill_clears_busy: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_FILL && !s.ctl.signature_read &&
     core_req.store_program_instruction) |=> !s.ctl.busy)
    else $error("busy flag survived buffer load");
  a_reenable_clears: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_REENABLE && core_req.store_program_instruction)
    |=> !section_read_block)
    else $error("section still blocked after re-enable");
  a_load_abort: assert property (
    (csr_wr && csr_wdata[4] && s.loading && s.fsm != ST_BUSY)
    |=> !s.loading)
    else $error("buffer load not aborted");
  a_sig_load_data: assert property (
    (s.fsm == ST_ARMED && s.ctl.signature_read && core_req.load_program_instruction &&
     s.cnt < `SPFC_LPM_WINDOW)
    |=> (lpm_valid && lpm_data == $past(sig_byte)))
    else $error("signature byte not returned");
  a_erase_start: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_ERASE && core_req.store_program_instruction &&
     !wr_blocked) |=> (flash_start && flash_erase &&
     flash_page == $past(z_page)))
    else $error("page erase not started");
  a_write_start: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_WRITE && core_req.store_program_instruction &&
     !wr_blocked) |=> (flash_start && !flash_erase))
    else $error("page write not started");
  a_app_write_blocked: assert property (
    (s.fsm == ST_ARMED && core_req.store_program_instruction && wr_blocked &&
     (op == `SPFC_OP_ERASE || op == `SPFC_OP_WRITE)) |=> !flash_start)
    else $error("store wrote a locked section");
  a_done_disarms: assert property (
    (s.fsm == ST_BUSY && flash_done) |=> (!s.ctl.store_enable &&
     !s.ctl.page_erase && !s.ctl.page_write))
    else $error("armed bits kept after completion");
  a_lock_boot_only: assert property (
    (s.fsm == ST_ARMED && op == `SPFC_OP_LOCK && core_req.store_program_instruction && !chip_erase)
    |=> ((lock_byte & ~`SPFC_BOOT_MASK) ==
         ($past(s.lock) & ~`SPFC_BOOT_MASK)))
    else $error("lock write touched other bits");
  a_busy_write_refused: assert property (
    (csr_wr && s.fsm == ST_BUSY && !flash_done)
    |=> (s.fsm == ST_BUSY && !s.ctl.reenable))
    else $error("control write acted while busy");
  a_halt_no_read_while_write_section: assert property (
    (s.flash_start && s.page >= NO_READ_WHILE_WRITE_SECTION_PAGE) |-> core_halt)
    else $error("core not halted for protected page");

  c_buffer_fill: cover property (
    s.fsm == ST_ARMED && op == `SPFC_OP_FILL && core_req.store_program_instruction);
  c_erase_done: cover property (
    s.fsm == ST_BUSY && s.erase && flash_done);
  c_lock_set: cover property (
    s.fsm == ST_ARMED && op == `SPFC_OP_LOCK && core_req.store_program_instruction);
  c_page_write_no_read_while_write_section: cover property (
    s.flash_start && !s.erase && s.page >= NO_READ_WHILE_WRITE_SECTION_PAGE);
  c_sig_read: cover property (
    lpm_valid && s.ctl.signature_read);

endmodule

//--- core/spfc_defines.svh
// constants for the self-programming flash control block
// assumes inclusion by spfc_pkg and spfc_core only
//
// Overview of operation
// - signature-read arming: load within three cycles returns signature
// - store within four cycles of signature-read arming does nothing
// - erase or write to read-while-write section sets busy, blocks its reads
// - re-enable arming: store within four cycles re-enables the section
// - no re-enable while erase or write runs; software waits for clear
// - section-read-enable written during buffer load aborts load, drops data
// - lock-set arming: store within four cycles programs boot locks from R0
// - lock-set clears on completion or four cycles without a store
// - lock-set arming: load within three cycles returns lock or fuse by Z0
// - page-write arming: store within four cycles writes buffer to page
// - page-write clears on completion or four cycles without a store
// - core halted for whole erase or write of no-read-while-write page
// - page-erase arming: store within four cycles erases addressed page
// - page-erase clears on completion or four cycles without a store
// - plain store-enable: store puts R1:R0 in buffer word, Z0 ignored
// - store-enable opens four cycles, clears on store done or timeout
// - store-enable stays set during erase or write as completion flag
// - control writes with invalid low six bits arm nothing; bit 7 is still taken
// - lock byte: six bits, 1 unprogrammed, only chip erase or reset restores ones
// - memory lock mode 2 blocks programming, fuses; mode 3 adds verify
// - boot lock pair 0 restricts application section writes and reads
// - boot lock pair 1 restricts boot section writes and reads
// - busy clears on re-enable after completion or on buffer load
// - store-ready interrupt requested while enabled and store-enable clear
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH

`define SPFC_PAGE_W      10
`define SPFC_WORD_W      7
`define SPFC_Z_W         18
`define SPFC_OP_FILL     5'h01
`define SPFC_OP_ERASE    5'h03
`define SPFC_OP_WRITE    5'h05
`define SPFC_OP_LOCK     5'h09
`define SPFC_OP_REENABLE 5'h11
`define SPFC_SPM_LAST    3'h3
`define SPFC_LPM_WINDOW  3'h3
`define SPFC_CSR_RESET   8'h00
`define SPFC_LOCK_ERASED 8'hff
`define SPFC_BOOT_MASK   8'h3c
`define SPFC_NO_READ_WHILE_WRITE_SECTION_PAGE   10'h3e0
`define SPFC_BUF_BLANK   16'hffff

`endif

//--- core/spfc_pkg.sv
// types shared by the self-programming flash control block
// assumes spfc_defines.svh on the include path
`include "spfc_defines.svh"

package spfc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_BUSY  = 2'h3
  } spfc_fsm_t;

  // control and status register, bit 7 down to bit 0
  typedef struct packed {
    logic store_ready_irq_enable;
    logic busy;
    logic signature_read;
    logic reenable;
    logic lock_set;
    logic page_write;
    logic page_erase;
    logic store_enable;
  } spfc_ctl_t;

  typedef struct packed {
    logic                  store_program_instruction;
    logic                  load_program_instruction;
    logic [`SPFC_Z_W-1:0]  z;
    logic [7:0]            r1;
    logic [7:0]            r0;
  } spfc_core_req_t;

  typedef struct packed {
    logic ext_prog_block;
    logic ext_verify_block;
    logic fuse_locked;
    logic boot_locks_frozen;
    logic app_write_block;
    logic boot_write_block;
    logic boot_read_app_block;
    logic app_read_boot_block;
    logic irq_mask;
  } spfc_prot_t;

  typedef struct packed {
    spfc_fsm_t               fsm;
    logic [2:0]              cnt;
    spfc_ctl_t               ctl;
    logic                    loading;
    logic [7:0]              lock;
    logic [7:0]              lpm_data;
    logic                    lpm_valid;
    logic                    flash_start;
    logic [`SPFC_PAGE_W-1:0] page;
    logic                    erase;
    logic                    halt;
  } spfc_state_t;

endpackage

//--- verification/spfc_flash_model.sv
// flash array stand-in: answers each start pulse with a done pulse
// assumes flash_start is a one-cycle pulse synchronous to mclk
`timescale 1ns/100ps

module spfc_flash_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] delay,
  input  wire logic       flash_start,
  output      logic       flash_done
);
  logic [7:0] left;
  logic       run;

  // ****************************************************
  // busy count, prompt or slow by delay
  // ****************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      left <= 8'h00;
      flash_done <= 1'b0;
    end else begin
      flash_done <= 1'b0;
      if (flash_start) begin
        run <= 1'b1;
        left <= delay;
      end else if (run) begin
        if (left == 8'h00) begin
          flash_done <= 1'b1;
          run <= 1'b0;
        end else begin
          left <= left - 8'h01;
        end
      end
    end
  end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the self-programming flash control block
// assumes spfc_pkg compiled first and the flash model beside it
`timescale 1ns/100ps

module tb_top;
  import spfc_pkg::*;
  logic             mclk, reset_n, csr_wr, global_irq_en, chip_erase;
  logic             pc_in_boot, vectors_in_boot, flash_done, lpm_valid;
  logic             flash_start, flash_erase, core_halt, store_ready_irq;
  logic             section_read_block;
  logic [7:0]       csr_wdata, csr_rdata, lpm_data, fuse_byte, sig_byte;
  logic [7:0]       lock_byte, flash_delay, v, lr, lx;
  logic [9:0]       flash_page, pg;
  logic [6:0]       buf_rd_addr;
  logic [15:0]      buf_rd_data, wd;
  spfc_core_req_t   core_req;
  spfc_prot_t       prot;
  logic [7:0]       ops [6] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21};
  logic [7:0]       exp_q [$];
  int               errors = 0;
  int               n_checks = 0;
  int               n_starts = 0;

  spfc_core spfc_core_i (.mclk(mclk), .reset_n(reset_n), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .core_req(core_req),
    .lpm_data(lpm_data), .lpm_valid(lpm_valid), .fuse_byte(fuse_byte),
    .sig_byte(sig_byte), .global_irq_en(global_irq_en),
    .pc_in_boot(pc_in_boot), .vectors_in_boot(vectors_in_boot),
    .chip_erase(chip_erase), .flash_start(flash_start),
    .flash_page(flash_page), .flash_erase(flash_erase),
    .flash_done(flash_done), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data), .lock_byte(lock_byte),
    .core_halt(core_halt), .section_read_block(section_read_block),
    .store_ready_irq(store_ready_irq), .prot(prot));

  spfc_flash_model spfc_flash_model_i (.mclk(mclk), .reset_n(reset_n),
    .delay(flash_delay), .flash_start(flash_start),
    .flash_done(flash_done));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic close_out;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] d);
    csr_wr = 1'b1;
    csr_wdata = d;
    @(negedge mclk);
    csr_wr = 1'b0;
  endtask

  task automatic req(input logic s, input logic l, input logic [17:0] z,
                     input logic [15:0] d);
    core_req.store_program_instruction = s;
    core_req.load_program_instruction = l;
    core_req.z = z;
    core_req.r1 = d[15:8];
    core_req.r0 = d[7:0];
    @(negedge mclk);
    core_req.store_program_instruction = 1'b0;
    core_req.load_program_instruction = 1'b0;
  endtask

  task automatic wait_idle;
    int k = 0;
    while ((csr_rdata[0] !== 1'b0 || core_halt !== 1'b0) && k < 200) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 200) begin
      errors++;
      $display("BAD %0t operation never finished", $time);
      close_out();
    end
  endtask

  // ****************************************************
  // result watcher: oldest note against each load result
  // ****************************************************
  always @(posedge mclk) begin
    #1;
    if (flash_start === 1'b1)
      n_starts++;
    if (lpm_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check(16'(lpm_data), 16'hxxxx);
      else
        check(16'(lpm_data), 16'(exp_q.pop_front()));
    end
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("BAD %0t run limit reached", $time);
    close_out();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(97));
    reset_n = 1'b0;
    csr_wr = 1'b0;
    csr_wdata = 8'h00;
    core_req = '0;
    fuse_byte = 8'($urandom);
    sig_byte = 8'($urandom);
    global_irq_en = 1'b1;
    pc_in_boot = 1'($urandom);
    vectors_in_boot = 1'($urandom);
    chip_erase = 1'b0;
    buf_rd_addr = 7'h00;
    flash_delay = 8'h01;
    tick(12);
    reset_n = 1'b1;
    tick(1);
    check(16'(csr_rdata), 16'h0000);
    check(16'(lock_byte), 16'h00ff);
    check(buf_rd_data, 16'hffff);
    // word fill, pointer low bit set on purpose
    wd = 16'($urandom);
    wr(8'h01);
    req(1'b1, 1'b0, {10'd3, 7'd5, 1'b1}, wd);
    tick(1);
    check(16'(csr_rdata), 16'h0000);
    buf_rd_addr = 7'd5;
    tick(1);
    check(buf_rd_data, wd);
    wr(8'h11);
    tick(1);
    check(buf_rd_data, 16'hffff);
    tick(5);
    foreach (ops[i]) begin
      wr(ops[i]);
      tick(3);
      check(16'(csr_rdata), 16'(ops[i]));
      tick(2);
      check(16'(csr_rdata), 16'h0000);
    end
    repeat (10) begin
      v = 8'($urandom) & 8'h3f;
      if (!(v inside {8'h01, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21})) begin
        wr(v);
        tick(1);
        check(16'(csr_rdata), 16'h0000);
      end
    end
    // erase in the read-while-write section, slow flash
    flash_delay = 8'd20;
    pg = 10'($urandom % 992);
    wr(8'h03);
    req(1'b1, 1'b0, {pg, 8'h00}, 16'($urandom));
    tick(1);
    check(16'(flash_page), 16'(pg));
    check(16'(flash_erase), 16'h0001);
    check(16'(section_read_block), 16'h0001);
    check(16'(core_halt), 16'h0000);
    check(16'(csr_rdata), 16'h0043);
    wr(8'h11);
    tick(1);
    check(16'(csr_rdata), 16'h0043);
    wait_idle();
    check(16'(csr_rdata), 16'h0040);
    wr(8'h11);
    req(1'b1, 1'b0, 18'h00000, 16'h0000);
    tick(1);
    check(16'(section_read_block), 16'h0000);
    check(16'(n_starts), 16'h0001);
    // write in the no-read-while-write section
    flash_delay = 8'd30;
    wr(8'h05);
    req(1'b1, 1'b0, {10'd1000, 8'h00}, 16'($urandom));
    tick(1);
    check(16'(flash_erase), 16'h0000);
    check(16'(flash_page), 16'd1000);
    tick(10);
    check(16'(core_halt), 16'h0001);
    wait_idle();
    check(16'(csr_rdata), 16'h0000);
    check(16'(n_starts), 16'h0002);
    // signature read, store in its window does nothing
    wr(8'h21);
    exp_q.push_back(sig_byte);
    req(1'b0, 1'b1, 18'($urandom), 16'h0000);
    tick(1);
    req(1'b1, 1'b0, 18'h00000, 16'h0000);
    check(16'(csr_rdata), 16'h0021);
    tick(5);
    wr(8'h09);
    exp_q.push_back(8'hff);
    req(1'b0, 1'b1, 18'h00001, 16'h0000);
    tick(5);
    wr(8'h09);
    exp_q.push_back(fuse_byte);
    req(1'b0, 1'b1, 18'h00000, 16'h0000);
    tick(5);
    // boot locks from R0, application pair forced to mode 2 or 3
    lr = 8'($urandom) & 8'hfb;
    lx = 8'hff & (lr | 8'hc3);
    wr(8'h09);
    req(1'b1, 1'b0, 18'($urandom), {8'($urandom), lr});
    tick(1);
    check(16'(lock_byte), 16'(lx));
    check(16'(csr_rdata), 16'h0000);
    check(16'(prot.app_write_block), 16'h0001);
    check(16'(prot.boot_read_app_block), 16'(!lx[3] && pc_in_boot));
    check(16'(prot.boot_write_block), 16'(!lx[4]));
    check(16'(prot.app_read_boot_block), 16'(!lx[5] && !pc_in_boot));
    check(16'(prot.irq_mask), vectors_in_boot ? 16'(!lx[3] && !pc_in_boot)
          : 16'(!lx[5] && pc_in_boot));
    check(16'(prot.fuse_locked), 16'h0000);
    check(16'(prot.boot_locks_frozen), 16'h0000);
    check(16'(prot.ext_prog_block), 16'h0000);
    check(16'(prot.ext_verify_block), 16'h0000);
    wr(8'h03);
    req(1'b1, 1'b0, {10'd5, 8'h00}, 16'h0000);
    tick(1);
    check(16'(n_starts), 16'h0002);
    check(16'(csr_rdata), 16'h0000);
    chip_erase = 1'b1;
    tick(1);
    chip_erase = 1'b0;
    tick(1);
    check(16'(lock_byte), 16'h00ff);
    // store-ready request
    wr(8'h80);
    check(16'(store_ready_irq), 16'h0001);
    tick(1);
    wr(8'h81);
    check(16'(store_ready_irq), 16'h0000);
    tick(6);
    check(16'(store_ready_irq), 16'h0001);
    global_irq_en = 1'b0;
    tick(1);
    check(16'(store_ready_irq), 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule
